// file: verilog/uart_params.svh
`ifndef UART_PARAMS_SVH
`define UART_PARAMS_SVH
// Behaviour
// - Serial port has receive, transmit, request-to-send and clear-to-send lines.
// - Bit rate is adjustable from 9600 bps up to 4.0 Mbps.
// - Automatic detection measures host traffic and yields a divisor.
// - Host may change the rate; the divisor register is then rewritten.
// - Separate 1040-byte receive and transmit FIFOs.
// - Both FIFOs are reachable from the internal bus by DMA or CPU.
// - Both H4 and H5 transport variants are supported.
// - After reset the port runs at 115.2 Kbaud.
// - In H5 mode request-to-send is not driven and clear-to-send is used only for wake while asleep.
// - In-band XON/XOFF pauses and resumes transmission.
// - Hardware SLIP delimiting and escape handling in both directions.
// - While asleep, receive or clear-to-send activity raises a wake request.
// - Rate comes from a record loaded after reset or from detection.
// - Summed rate error of both ends must stay within two percent.
// - Transmit starts within 1.5 bit periods of clear-to-send going low.
// - Request-to-send rises within 0.5 bit after stop bit midpoint.
`define CLK_HZ      100000000
`define BAUD_MIN    9600
`define BAUD_MAX    4000000
`define BAUD_DEF    115200
`define DIV_W       14
`define DIV_DEF     (`CLK_HZ / `BAUD_DEF)
`define DIV_MIN     (`CLK_HZ / `BAUD_MAX)
`define DIV_MAX     (`CLK_HZ / `BAUD_MIN)
`define FIFO_DEPTH  1040
`define RTS_THR_DEF 16
`define DATA_BITS   8
`define A_CTRL      8'h00
`define A_DIV       8'h04
`define A_DATA      8'h08
`define A_STAT      8'h0C
`define A_INT       8'h10
`define A_MASK      8'h14
`define A_THR       8'h18
`define C_H5        0
`define C_XON       1
`define C_SLIP      2
`define C_ABAUD     3
`define C_SLEEP     4
`define CTRL_W      5
`define I_RX        0
`define I_FRM       1
`define I_ABD       2
`define I_WAKE      3
`define I_OVF       4
`define I_FERR      5
`define INT_W       6
`define S_TXCNT     16
`define S_ABUSY     30
`define S_PAUSE     31
`define D_DELIM     8
`define SLIP_END    8'hC0
`define SLIP_ESC    8'hDB
`define SLIP_EEND   8'hDC
`define SLIP_EESC   8'hDD
`define XON_CHAR    8'h11
`define XOFF_CHAR   8'h13
`endif

// file: verilog/uart_pkg.sv
package uart_pkg;
  typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_LOAD = 2'b01, TX_SHIFT = 2'b10} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10, RX_STOP = 2'b11} rx_state_t;
  typedef enum logic [1:0] {AB_OFF = 2'b00, AB_WAIT = 2'b01, AB_MEAS = 2'b10} ab_state_t;
endpackage : uart_pkg

// file: verilog/fifo_buf.sv
`timescale 1ns/1ns
`default_nettype none
module fifo_buf #(
  parameter int W     = 9,
  parameter int DEPTH = 1040,
  parameter int CW    = $clog2(DEPTH + 1)
) (
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // Fill side
  input  wire logic          push,
  input  wire logic [W-1:0]  wdata,
  // Drain side, data valid the cycle after pop
  input  wire logic          pop,
  output logic      [W-1:0]  rdata,
  // Fill level
  output logic      [CW-1:0] count,
  output logic               full,
  output logic               empty
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wptr_reg;
  logic [PW-1:0] rptr_reg;
  logic          do_push;
  logic          do_pop;

  assign full    = (count == CW'(DEPTH));
  assign empty   = (count == '0);
  assign do_push = push && !full;
  assign do_pop  = pop && !empty;

  always_ff @(posedge pclk) begin
    if (do_push) begin
      mem[wptr_reg] <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= '0;
    end else if (do_pop) begin
      rdata <= mem[rptr_reg];
    end
  end

  // Depth need not be a power of two, so pointers wrap explicitly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count    <= '0;
    end else begin
      if (do_push) begin
        wptr_reg <= (wptr_reg == PW'(DEPTH - 1)) ? '0 : wptr_reg + 1'b1;
      end
      if (do_pop) begin
        rptr_reg <= (rptr_reg == PW'(DEPTH - 1)) ? '0 : rptr_reg + 1'b1;
      end
      count <= count + CW'(do_push) - CW'(do_pop);
    end
  end
endmodule : fifo_buf
`default_nettype wire

// file: verilog/bt_hci_uart.sv
`timescale 1ns/1ns
`default_nettype none
`include "uart_params.svh"
module bt_hci_uart import uart_pkg::*; #(
  parameter int DEPTH = `FIFO_DEPTH,
  parameter int DIV_W = `DIV_W
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Host serial pins
  input  wire logic        rxd,
  output logic             txd,
  input  wire logic        cts_n,
  output logic             rts_n,
  // System
  output logic             irq,
  output logic             wake_req
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int FW = `DATA_BITS + 1;

  if (DEPTH < 2 || DIV_W < $clog2(`DIV_MAX + 1)) begin : g_bad_param
    $error("bt_hci_uart: depth or divisor width too small");
  end

  logic [`CTRL_W-1:0] ctrl_reg;
  logic [DIV_W-1:0]   div_reg, tx_cnt, rx_cnt, ab_cnt;
  logic [CW-1:0]      thr_reg, rx_count, tx_count;
  logic [`INT_W-1:0]  mask_reg, int_stat, ev;
  logic [FW-1:0]      rx_wdata, rx_rdata, tx_rdata;
  logic [9:0]         tx_shift;
  logic [7:0]         esc_byte_reg, rx_shift;
  logic [3:0]         tx_bit;
  logic [2:0]         rx_bit;
  logic               h5, rx_m, rx_s, rx_d, cts_m, cts_s, cts_d;
  logic               acc, wr_en, rd_done, data_rd, rd_wait_reg, mapped;
  logic               rx_push, rx_pop, rx_full, rx_empty, tx_push, tx_pop, tx_full, tx_empty;
  logic               rx_pop_empty_reg, esc_pend_reg, paused_reg, rx_esc_reg, byte_done, ab_done;
  tx_state_t          tx_state;
  rx_state_t          rx_state;
  ab_state_t          ab_state;
  assign h5 = ctrl_reg[`C_H5];
  // Pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {rx_m, rx_s, rx_d}    <= 3'h7;
      {cts_m, cts_s, cts_d} <= 3'h7;
    end else begin
      {rx_m, rx_s, rx_d}    <= {rxd, rx_m, rx_s};
      {cts_m, cts_s, cts_d} <= {cts_n, cts_m, cts_s};
    end
  end

  // APB decode; data reads take one wait state for the registered FIFO output
  assign acc     = psel && penable;
  assign data_rd = acc && !pwrite && (paddr == `A_DATA);
  assign pready  = !data_rd || rd_wait_reg;
  assign wr_en   = acc && pwrite && pready;
  assign rd_done = acc && !pwrite && pready;
  assign mapped  = (paddr == `A_CTRL) || (paddr == `A_DIV) || (paddr == `A_DATA) || (paddr == `A_STAT) ||
                   (paddr == `A_INT) || (paddr == `A_MASK) || (paddr == `A_THR);
  assign pslverr = acc && pready && !mapped;
  assign rx_pop  = data_rd && !rd_wait_reg;
  assign tx_push = wr_en && (paddr == `A_DATA);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_wait_reg      <= 1'b0;
      rx_pop_empty_reg <= 1'b0;
    end else begin
      rd_wait_reg      <= rx_pop;
      rx_pop_empty_reg <= rx_pop && rx_empty;
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      `A_CTRL: prdata[`CTRL_W-1:0] = ctrl_reg;
      `A_DIV:  prdata[DIV_W-1:0]   = div_reg;
      `A_DATA: prdata[FW-1:0]      = rx_pop_empty_reg ? '0 : rx_rdata;
      `A_STAT: begin
        prdata[CW-1:0]                 = rx_count;
        prdata[`S_TXCNT +: CW]         = tx_count;
        prdata[`S_ABUSY]               = (ab_state != AB_OFF);
        prdata[`S_PAUSE]               = paused_reg;
      end
      `A_INT:  prdata[`INT_W-1:0]  = int_stat;
      `A_MASK: prdata[`INT_W-1:0]  = mask_reg;
      `A_THR:  prdata[CW-1:0]      = thr_reg;
      default: prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= '0;
      mask_reg <= '0;
      thr_reg  <= CW'(`RTS_THR_DEF);
    end else if (wr_en) begin
      if (paddr == `A_CTRL) begin
        ctrl_reg <= pwdata[`CTRL_W-1:0] & ~(`CTRL_W'(1) << `C_ABAUD);
      end
      if (paddr == `A_MASK) begin
        mask_reg <= pwdata[`INT_W-1:0];
      end
      if (paddr == `A_THR) begin
        thr_reg <= pwdata[CW-1:0];
      end
    end
  end

  // Divisor: reset value, software (configuration record or host command) or detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= DIV_W'(`DIV_DEF);
    end else if (ab_done) begin
      div_reg <= ab_cnt;
    end else if (wr_en && paddr == `A_DIV && pwdata[DIV_W-1:0] >= DIV_W'(`DIV_MIN)) begin
      div_reg <= pwdata[DIV_W-1:0];
    end
  end

  // Autobaud: the host's first start bit is one bit long when data bit 0 is high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ab_state <= AB_OFF;
      ab_cnt   <= '0;
    end else begin
      case (ab_state)
        AB_OFF: begin
          if (wr_en && paddr == `A_CTRL && pwdata[`C_ABAUD]) begin
            ab_state <= AB_WAIT;
          end
        end
        AB_WAIT: begin
          ab_cnt <= DIV_W'(1);
          if (!rx_s) begin
            ab_state <= AB_MEAS;
          end
        end
        AB_MEAS: begin
          if (rx_s) begin
            ab_state <= (ab_cnt >= DIV_W'(`DIV_MIN)) ? AB_OFF : AB_WAIT;
          end else if (ab_cnt != '1) begin
            ab_cnt <= ab_cnt + 1'b1;
          end
        end
        default: ab_state <= AB_OFF;
      endcase
    end
  end
  assign ab_done = (ab_state == AB_MEAS) && rx_s && (ab_cnt >= DIV_W'(`DIV_MIN));
  fifo_buf #(.W(FW), .DEPTH(DEPTH), .CW(CW)) u_rx_fifo (
    .pclk(pclk), .presetn(presetn), .push(rx_push), .wdata(rx_wdata), .pop(rx_pop),
    .rdata(rx_rdata), .count(rx_count), .full(rx_full), .empty(rx_empty));
  fifo_buf #(.W(FW), .DEPTH(DEPTH), .CW(CW)) u_tx_fifo (
    .pclk(pclk), .presetn(presetn), .push(tx_push), .wdata(pwdata[FW-1:0]), .pop(tx_pop),
    .rdata(tx_rdata), .count(tx_count), .full(tx_full), .empty(tx_empty));
  // Transmitter; flow control is checked only between characters
  assign tx_pop = (tx_state == TX_IDLE) && !esc_pend_reg && !tx_empty && !paused_reg && (h5 || !cts_s);
  assign txd    = (tx_state == TX_SHIFT) ? tx_shift[0] : 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state     <= TX_IDLE;
      tx_shift     <= '1;
      tx_bit       <= '0;
      tx_cnt       <= '0;
      esc_pend_reg <= 1'b0;
      esc_byte_reg <= '0;
    end else begin
      case (tx_state)
        TX_IDLE: begin
          tx_bit <= '0;
          tx_cnt <= div_reg - 1'b1;
          if (esc_pend_reg) begin
            tx_shift     <= {1'b1, esc_byte_reg, 1'b0};
            esc_pend_reg <= 1'b0;
            tx_state     <= TX_SHIFT;
          end else if (tx_pop) begin
            tx_state <= TX_LOAD;
          end
        end
        TX_LOAD: begin
          tx_state <= TX_SHIFT;
          if (tx_rdata[`D_DELIM]) begin
            tx_shift <= {1'b1, `SLIP_END, 1'b0};
          end else if (ctrl_reg[`C_SLIP] && (tx_rdata[7:0] == `SLIP_END || tx_rdata[7:0] == `SLIP_ESC)) begin
            tx_shift     <= {1'b1, `SLIP_ESC, 1'b0};
            esc_pend_reg <= 1'b1;
            esc_byte_reg <= (tx_rdata[7:0] == `SLIP_END) ? `SLIP_EEND : `SLIP_EESC;
          end else begin
            tx_shift <= {1'b1, tx_rdata[7:0], 1'b0};
          end
        end
        TX_SHIFT: begin
          if (tx_cnt == '0) begin
            tx_cnt   <= div_reg - 1'b1;
            tx_shift <= {1'b1, tx_shift[9:1]};
            tx_bit   <= tx_bit + 1'b1;
            if (tx_bit == 4'(`DATA_BITS + 1)) begin
              tx_state <= TX_IDLE;
            end
          end else begin
            tx_cnt <= tx_cnt - 1'b1;
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end
  // Receiver samples each bit at its midpoint
  assign byte_done = (rx_state == RX_STOP) && (rx_cnt == '0);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state <= RX_IDLE;
      rx_shift <= '0;
      rx_bit   <= '0;
      rx_cnt   <= '0;
    end else begin
      case (rx_state)
        RX_IDLE: begin
          rx_bit <= '0;
          rx_cnt <= div_reg >> 1;
          if (!rx_s) begin
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          if (rx_cnt == '0) begin
            rx_cnt   <= div_reg - 1'b1;
            rx_state <= rx_s ? RX_IDLE : RX_DATA;
          end else begin
            rx_cnt <= rx_cnt - 1'b1;
          end
        end
        RX_DATA: begin
          if (rx_cnt == '0) begin
            rx_cnt   <= div_reg - 1'b1;
            rx_shift <= {rx_s, rx_shift[7:1]};
            rx_bit   <= rx_bit + 1'b1;
            if (rx_bit == 3'(`DATA_BITS - 1)) begin
              rx_state <= RX_STOP;
            end
          end else begin
            rx_cnt <= rx_cnt - 1'b1;
          end
        end
        RX_STOP: begin
          if (rx_cnt == '0) begin
            rx_state <= RX_IDLE;
          end else begin
            rx_cnt <= rx_cnt - 1'b1;
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // Received character handling: XON/XOFF, SLIP decode, FIFO write
  always_comb begin
    rx_push  = 1'b0;
    rx_wdata = {1'b0, rx_shift};
    if (byte_done && rx_s) begin
      if (ctrl_reg[`C_XON] && (rx_shift == `XON_CHAR || rx_shift == `XOFF_CHAR)) begin
        rx_push = 1'b0;
      end else if (ctrl_reg[`C_SLIP] && rx_shift == `SLIP_END) begin
        rx_push  = 1'b1;
        rx_wdata = {1'b1, `SLIP_END};
      end else if (ctrl_reg[`C_SLIP] && rx_shift == `SLIP_ESC) begin
        rx_push = 1'b0;
      end else begin
        rx_push = 1'b1;
        if (rx_esc_reg && rx_shift == `SLIP_EEND) begin
          rx_wdata = {1'b0, `SLIP_END};
        end else if (rx_esc_reg && rx_shift == `SLIP_EESC) begin
          rx_wdata = {1'b0, `SLIP_ESC};
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      paused_reg <= 1'b0;
      rx_esc_reg <= 1'b0;
    end else begin
      if (!ctrl_reg[`C_XON]) begin
        paused_reg <= 1'b0;
      end else if (byte_done && rx_s && rx_shift == `XOFF_CHAR) begin
        paused_reg <= 1'b1;
      end else if (byte_done && rx_s && rx_shift == `XON_CHAR) begin
        paused_reg <= 1'b0;
      end
      if (byte_done && rx_s && ctrl_reg[`C_SLIP]) begin
        rx_esc_reg <= (rx_shift == `SLIP_ESC);
      end
    end
  end

  // Handshake output; registered every cycle, high while free space is below the threshold or in H5
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rts_n <= 1'b1;
    end else begin
      rts_n <= h5 || (CW'(DEPTH) - rx_count < thr_reg);
    end
  end

  // Events and interrupt status; a new event wins over the read clear
  always_comb begin
    ev          = '0;
    ev[`I_RX]   = rx_push && !rx_full;
    ev[`I_FRM]  = rx_push && rx_wdata[`D_DELIM];
    ev[`I_ABD]  = ab_done;
    ev[`I_WAKE] = ctrl_reg[`C_SLEEP] && ((rx_d && !rx_s) || (cts_d != cts_s));
    ev[`I_OVF]  = (rx_push && rx_full) || (tx_push && tx_full);
    ev[`I_FERR] = byte_done && !rx_s;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat <= '0;
    end else if (rd_done && paddr == `A_INT) begin
      int_stat <= ev;
    end else begin
      int_stat <= int_stat | ev;
    end
  end

  assign irq      = |(int_stat & mask_reg);
  assign wake_req = int_stat[`I_WAKE];
  h5_no_rts_a: assert property (@(posedge pclk) disable iff (!presetn)
    h5 && $past(h5) |-> rts_n) else $error("rts driven in three-wire mode");
  idle_line_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_state != TX_SHIFT |-> txd) else $error("line not idle high");
  start_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_state == TX_LOAD |=> !txd ##1 !txd) else $error("start bit missing");
  div_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == `A_DIV && !ab_done && pwdata[DIV_W-1:0] >= DIV_W'(`DIV_MIN)
    |=> div_reg == $past(pwdata[DIV_W-1:0])) else $error("divisor not rewritten");
  xoff_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    paused_reg && tx_state == TX_IDLE |=> tx_state != TX_LOAD) else $error("sent while paused");
  cts_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_state == TX_IDLE && !esc_pend_reg && !tx_empty && !paused_reg && !h5 && !cts_s
    |=> tx_state == TX_LOAD ##1 tx_state == TX_SHIFT) else $error("late transmit start");
  slip_esc_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_state == TX_LOAD && ctrl_reg[`C_SLIP] && !tx_rdata[`D_DELIM] && tx_rdata[7:0] == `SLIP_END
    |=> tx_shift[8:1] == `SLIP_ESC && esc_byte_reg == `SLIP_EEND) else $error("SLIP escape wrong");
  rts_thr_a: assert property (@(posedge pclk) disable iff (!presetn)
    !h5 && (CW'(DEPTH) - rx_count >= thr_reg) |=> !rts_n) else $error("rts lifted with space left");
  wake_sleep_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[`C_SLEEP] && rx_d && !rx_s |=> wake_req) else $error("wake missed");
endmodule : bt_hci_uart
`default_nettype wire

// file: verif/host_uart.sv
`timescale 1ns/1ns
`default_nettype none
module host_uart #(
  parameter int DIV = 25
) (
  // Clock
  input  wire logic pclk,
  // Serial pins
  input  wire logic txd,
  input  wire logic rts_n,
  output logic      rxd,
  output logic      cts_n
);
  logic [7:0] rx_q[$];
  logic [7:0] sh;

  initial begin
    rxd = 1'b1;
    cts_n = 1'b0;
  end

  // Same bit time as the device, so the summed rate error is zero
  // The bench only lifts clear-to-send between characters, well ahead of any stop bit
  task automatic set_cts(input logic v);
    cts_n <= v;
  endtask : set_cts

  // A low stop bit is followed by one idle bit so the line returns high
  task automatic send(input logic [7:0] b, input logic stop, output bit late);
    int k;
    k = 0;
    while (rts_n !== 1'b0 && k < 5000) begin
      @(posedge pclk);
      k++;
    end
    late = (k >= 5000);
    if (late) return;
    for (int i = 0; i < 10; i++) begin
      rxd <= (i == 0) ? 1'b0 : (i == 9) ? stop : b[i-1];
      repeat (DIV) @(posedge pclk);
    end
    if (!stop) begin
      rxd <= 1'b1;
      repeat (DIV) @(posedge pclk);
    end
  endtask : send

  // Mid-bit sampling; a character with a low stop bit is not queued
  always begin
    @(negedge txd);
    repeat (DIV / 2) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      repeat (DIV) @(posedge pclk);
      sh[i] = txd;
    end
    repeat (DIV) @(posedge pclk);
    if (txd === 1'b1) rx_q.push_back(sh);
  end
endmodule : host_uart
`default_nettype wire

// file: verif/bt_hci_uart_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "uart_params.svh"
module bt_hci_uart_tb;
  localparam int D = 25;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        txd, rts_n, irq, wake_req, rxd, cts_n, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  int          n_fail, tests_run, n;

  bt_hci_uart u_bt_hci_uart (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd), .txd(txd), .cts_n(cts_n), .rts_n(rts_n), .irq(irq),
    .wake_req(wake_req));
  host_uart #(.DIV(D)) u_host_uart (.pclk(pclk), .txd(txd), .rts_n(rts_n), .rxd(rxd), .cts_n(cts_n));

  always #5 pclk = ~pclk;

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Holds the request until pready is seen high, then idles one cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_fail++;
      end_of_test();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wait_q(input int m);
    int k;
    k = 0;
    while (u_host_uart.rx_q.size() < m && k < 2000) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 2000) begin
      n_fail++;
      end_of_test();
    end
  endtask : wait_q

  // A request-to-send that never falls ends the run
  task automatic tx_host(input logic [7:0] b, input logic stop);
    bit late;
    u_host_uart.send(b, stop, late);
    if (late) begin
      n_fail++;
      end_of_test();
    end
  endtask : tx_host

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    n_fail = 0;
    tests_run = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(txd, 1'b1);
    apb(1'b0, `A_DIV, 32'h0);
    chk(r, `DIV_DEF);
    chk(rts_n, 1'b0);
    apb(1'b0, 8'hFC, 32'h0);
    chk({r[30:0], e}, 32'h1);
    apb(1'b1, `A_DIV, D - 1);
    apb(1'b0, `A_DIV, 32'h0);
    chk(r, `DIV_DEF);
    apb(1'b1, `A_DIV, D);
    apb(1'b0, `A_DIV, 32'h0);
    chk(r, D);
    // Two queued bytes held back by clear-to-send
    u_host_uart.set_cts(1'b1);
    apb(1'b1, `A_DATA, 32'h5A);
    apb(1'b1, `A_DATA, 32'h81);
    repeat (100) @(posedge pclk);
    apb(1'b0, `A_STAT, 32'h0);
    chk(r[26:16], 11'h002);
    chk(u_host_uart.rx_q.size(), 32'h0);
    u_host_uart.set_cts(1'b0);
    n = 0;
    while (txd !== 1'b0 && n < 60) begin
      @(posedge pclk);
      n++;
    end
    chk(n <= 37, 1'b1);
    wait_q(2);
    chk(u_host_uart.rx_q.pop_front(), 32'h5A);
    chk(u_host_uart.rx_q.pop_front(), 32'h81);
    // Receive with a masked-in interrupt
    apb(1'b1, `A_MASK, 32'h1);
    tx_host(8'h3C, 1'b1);
    repeat (8) @(posedge pclk);
    chk(irq, 1'b1);
    apb(1'b1, `A_MASK, 32'h0);
    chk(irq, 1'b0);
    apb(1'b0, `A_STAT, 32'h0);
    chk(r[10:0], 11'h001);
    apb(1'b0, `A_DATA, 32'h0);
    chk(r, 32'h3C);
    apb(1'b0, `A_INT, 32'h0);
    chk(r[0], 1'b1);
    apb(1'b0, `A_INT, 32'h0);
    chk(r[0], 1'b0);
    // One stored byte crosses a threshold equal to the depth
    apb(1'b1, `A_THR, 32'd1040);
    tx_host(8'h77, 1'b1);
    chk(rts_n, 1'b1);
    apb(1'b0, `A_DATA, 32'h0);
    chk(r, 32'h77);
    chk(rts_n, 1'b0);
    apb(1'b1, `A_THR, 32'h10);
    apb(1'b1, `A_CTRL, 32'h2);
    tx_host(`XOFF_CHAR, 1'b1);
    repeat (4) @(posedge pclk);
    apb(1'b0, `A_STAT, 32'h0);
    chk({r[31], r[10:0]}, 12'h800);
    apb(1'b1, `A_DATA, 32'h33);
    repeat (300) @(posedge pclk);
    chk(u_host_uart.rx_q.size(), 32'h0);
    tx_host(`XON_CHAR, 1'b1);
    wait_q(1);
    chk(u_host_uart.rx_q.pop_front(), 32'h33);
    apb(1'b1, `A_CTRL, 32'h4);
    apb(1'b1, `A_DATA, 32'hC0);
    apb(1'b1, `A_DATA, 32'h1C0);
    wait_q(3);
    chk({u_host_uart.rx_q[0], u_host_uart.rx_q[1], u_host_uart.rx_q[2]}, 32'hDBDCC0);
    u_host_uart.rx_q.delete();
    tx_host(8'hDB, 1'b1);
    tx_host(8'hDD, 1'b1);
    tx_host(8'hC0, 1'b1);
    repeat (4) @(posedge pclk);
    apb(1'b0, `A_DATA, 32'h0);
    chk(r, 32'hDB);
    apb(1'b0, `A_DATA, 32'h0);
    chk(r, 32'h1C0);
    apb(1'b0, `A_INT, 32'h0);
    chk(r[1], 1'b1);
    // A low stop bit drops the character and flags a framing error only
    tx_host(8'h55, 1'b0);
    apb(1'b0, `A_INT, 32'h0);
    chk(r[5:0], 32'h20);
    apb(1'b0, `A_STAT, 32'h0);
    chk(r[10:0], 11'h000);
    // H5 ignores clear-to-send and leaves request-to-send high
    apb(1'b1, `A_CTRL, 32'h1);
    u_host_uart.set_cts(1'b1);
    apb(1'b1, `A_DATA, 32'hA5);
    wait_q(1);
    chk(u_host_uart.rx_q.pop_front(), 32'hA5);
    chk(rts_n, 1'b1);
    apb(1'b1, `A_CTRL, 32'h10);
    apb(1'b1, `A_MASK, 32'h8);
    u_host_uart.set_cts(1'b0);
    repeat (6) @(posedge pclk);
    chk({wake_req, irq}, 2'h3);
    apb(1'b1, `A_CTRL, 32'h0);
    apb(1'b0, `A_INT, 32'h0);
    chk({r[3], wake_req}, 2'h2);
    apb(1'b1, `A_CTRL, 32'h8);
    tx_host(8'hFE, 1'b1);
    repeat (4) @(posedge pclk);
    apb(1'b0, `A_DIV, 32'h0);
    chk(r, 2 * D);
    apb(1'b0, `A_INT, 32'h0);
    chk(r[2], 1'b1);
    end_of_test();
  end
endmodule : bt_hci_uart_tb
`default_nettype wire
